// >>> design/bus_timing_map.svh
// Bus phase timing figures, line indexes and cycle conversions
`ifndef BUS_TIMING_MAP_SVH
`define BUS_TIMING_MAP_SVH

`define CLK_PS 8000
`define PS_PER_NS 1000
`define PS_PER_US 1000000
`define PS_PER_S 64'd1000000000000
// Least times round up, longest times round down, never below one cycle
`define CYC_MIN(t) ((((t) + `CLK_PS - 1) / `CLK_PS) < 1 ? 1 : (((t) + `CLK_PS - 1) / `CLK_PS))
`define CYC_MAX(t) ((((t) / `CLK_PS) < 1) ? 1 : ((t) / `CLK_PS))

`define ARB_DLY_NS 2400
`define FREE_DLY_NS 800
`define SET_DLY_NS 1600
`define SETTLE_DLY_NS 400
`define DESKEW_NS 45
`define RST_HOLD_US 25
`define DISC_DLY_US 200
`define ABORT_US 200
`define POWER_S 10

`define ARB_CYC `CYC_MIN(`ARB_DLY_NS * `PS_PER_NS)
`define FREE_CYC `CYC_MIN(`FREE_DLY_NS * `PS_PER_NS)
`define SET_CYC `CYC_MAX(`SET_DLY_NS * `PS_PER_NS)
`define SETTLE_CYC `CYC_MIN(`SETTLE_DLY_NS * `PS_PER_NS)
`define DESKEW_CYC `CYC_MIN(`DESKEW_NS * `PS_PER_NS)
`define RST_HOLD_CYC `CYC_MIN(`RST_HOLD_US * `PS_PER_US)
`define DISC_CYC `CYC_MIN(`DISC_DLY_US * `PS_PER_US)
`define ABORT_CYC `CYC_MAX(`ABORT_US * `PS_PER_US)
`define POWER_CYC (`POWER_S * `PS_PER_S / `CLK_PS)
// Margin for the two-stage input sampling and the output register
`define SYNC_LAG 2

`define ST_PER_F5_PS 200000
`define ST_PER_F10_PS 100000
`define ST_PER_F20_PS 50000
`define ST_PER_F40_PS 25000
`define ST_ASRT_F5_PS 80000
`define ST_ASRT_F10_PS 30000
`define ST_ASRT_F20_PS 15000
`define ST_ASRT_F40_PS 8000
`define DT_PER_F10_PS 200000
`define DT_PER_F20_PS 100000
`define DT_PER_F40_PS 50000
`define DT_PER_F80_PS 25000
`define DT_ASRT_F10_PS 90000
`define DT_ASRT_F20_PS 45000
`define DT_ASRT_F40_PS 22500
`define DT_ASRT_F80_PS 11500

`define CTL_BSY 0
`define CTL_SEL 1
`define CTL_RST 2
`define CTL_IO 3
`define CTL_REQ 4
`define CTL_ACK 5
`define CTL_W 6
`define DAT_W 8

`endif

// >>> design/bus_timing_pkg.sv
// Shared types and strobe limit decoding for both bus ends
package bus_timing_pkg;
`include "bus_timing_map.svh"

  typedef enum logic [2:0] {ST_IDLE, ST_ARB, ST_CONN, ST_HOLD, ST_RST} dev_state_e;

  typedef struct packed {
    logic [5:0] asrt;
    logic [5:0] per;
  } strobe_lim_s;

  // Limits of the fastest rate of each class, whatever rate was negotiated
  function automatic strobe_lim_s strobe_lim(input logic dt, input logic [1:0] rate);
    strobe_lim_s r;
    int          a;
    int          p;
    case ({dt, rate})
      3'h0: begin a = `ST_ASRT_F5_PS; p = `ST_PER_F5_PS; end
      3'h1: begin a = `ST_ASRT_F10_PS; p = `ST_PER_F10_PS; end
      3'h2: begin a = `ST_ASRT_F20_PS; p = `ST_PER_F20_PS; end
      3'h3: begin a = `ST_ASRT_F40_PS; p = `ST_PER_F40_PS; end
      3'h4: begin a = `DT_ASRT_F10_PS; p = `DT_PER_F10_PS; end
      3'h5: begin a = `DT_ASRT_F20_PS; p = `DT_PER_F20_PS; end
      3'h6: begin a = `DT_ASRT_F40_PS; p = `DT_PER_F40_PS; end
      default: begin a = `DT_ASRT_F80_PS; p = `DT_PER_F80_PS; end
    endcase
    r.asrt = 6'(`CYC_MIN(a));
    r.per  = 6'(`CYC_MIN(p));
    return r;
  endfunction

endpackage

// >>> design/par_bus_if.sv
// Shared parallel bus: per-end drive and enable, wired-OR resolved lines
`timescale 1ns/10ps
interface par_bus_if;
  import bus_timing_pkg::*;

  logic [`CTL_W-1:0] dev_ctl_out;
  logic [`CTL_W-1:0] dev_ctl_oe;
  logic [`DAT_W-1:0] dev_dat_out;
  logic [`DAT_W-1:0] dev_dat_oe;
  logic [`CTL_W-1:0] peer_ctl_out;
  logic [`CTL_W-1:0] peer_ctl_oe;
  logic [`DAT_W-1:0] peer_dat_out;
  logic [`DAT_W-1:0] peer_dat_oe;
  logic [`CTL_W-1:0] ctl;
  logic [`DAT_W-1:0] dat;

  // A line is true while any end drives it true
  assign ctl = (dev_ctl_out & dev_ctl_oe) | (peer_ctl_out & peer_ctl_oe);
  assign dat = (dev_dat_out & dev_dat_oe) | (peer_dat_out & peer_dat_oe);

  modport dev_mp (
    output dev_ctl_out, dev_ctl_oe, dev_dat_out, dev_dat_oe,
    input  ctl, dat
  );
  modport peer_mp (
    output peer_ctl_out, peer_ctl_oe, peer_dat_out, peer_dat_oe,
    input  ctl, dat
  );
endinterface

// >>> design/bus_peer_end.sv
// Far bus party: plain line driving, strobe receive and paced answer strobes
`timescale 1ns/10ps
module bus_peer_end
  import bus_timing_pkg::*;
(
  input  wire logic             clock_in,     // System clock
  input  wire logic             reset_in,     // Async reset, high
  par_bus_if.peer_mp            bus,          // Bus side
  input  wire logic             bsy_in,       // Drive busy line
  input  wire logic             sel_in,       // Drive select line
  input  wire logic             rst_in,       // Drive bus reset line
  input  wire logic             io_in,        // Drive direction line
  input  wire logic             dat_drive_in, // Drive data lines
  input  wire logic [`DAT_W-1:0] dat_in,      // Data line values
  input  wire logic             dt_in,        // Double-transition mode
  input  wire logic [1:0]       rate_in,      // Rate class
  output logic [`DAT_W-1:0]     rx_data_out,  // Received word
  output logic                  rx_valid_out  // Word received pulse
);
  logic [`CTL_W-1:0] drv_ff;
  logic [`DAT_W-1:0] dat_oe_ff;
  logic [`DAT_W-1:0] dat_out_ff;
  logic [`DAT_W:0]   sync1_ff;
  logic [`DAT_W:0]   sync2_ff;
  logic              req_prev_ff;
  logic              ack_ff;
  logic [5:0]        hold_ff;
  logic [5:0]        per_ff;
  logic [3:0]        owed_ff;
  logic              req_s;
  logic              rx_edge;
  logic              go;
  strobe_lim_s       lim;

  assign bus.peer_ctl_out = drv_ff;
  assign bus.peer_ctl_oe  = drv_ff;
  assign bus.peer_dat_out = dat_out_ff;
  assign bus.peer_dat_oe  = dat_oe_ff;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      drv_ff     <= '0;
      dat_oe_ff  <= '0;
      dat_out_ff <= '0;
    end else begin
      drv_ff[`CTL_BSY] <= bsy_in;
      drv_ff[`CTL_SEL] <= sel_in;
      drv_ff[`CTL_RST] <= rst_in;
      drv_ff[`CTL_IO]  <= io_in;
      drv_ff[`CTL_REQ] <= 1'b0;
      drv_ff[`CTL_ACK] <= ack_ff;
      dat_oe_ff        <= {`DAT_W{dat_drive_in}};
      dat_out_ff       <= dat_in;
    end
  end

  // Strobe and data pass the same two stages, so they stay aligned
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      sync1_ff    <= '0;
      sync2_ff    <= '0;
      req_prev_ff <= 1'b0;
    end else begin
      sync1_ff    <= {bus.dat, bus.ctl[`CTL_REQ]};
      sync2_ff    <= sync1_ff;
      req_prev_ff <= req_s;
    end
  end

  assign req_s   = sync2_ff[0];
  // Single transition takes data on assertion, double on both edges
  assign rx_edge = dt_in ? (req_s ^ req_prev_ff) : (req_s & ~req_prev_ff);

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      rx_data_out  <= '0;
      rx_valid_out <= 1'b0;
    end else begin
      rx_valid_out <= rx_edge;
      if (rx_edge) begin
        rx_data_out <= sync2_ff[`DAT_W:1];
      end
    end
  end

  assign lim = strobe_lim(dt_in, rate_in);
  assign go  = (owed_ff != 4'h0) && (hold_ff >= lim.asrt) &&
               (dt_in ? (ack_ff || per_ff >= lim.per) : (!ack_ff && per_ff >= lim.per));

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      owed_ff <= '0;
    end else if (rx_edge && !go && owed_ff != 4'hf) begin
      owed_ff <= owed_ff + 4'h1;
    end else if (go && !rx_edge) begin
      owed_ff <= owed_ff - 4'h1;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      ack_ff  <= 1'b0;
      hold_ff <= 6'h3f;
      per_ff  <= 6'h3f;
    end else begin
      hold_ff <= (hold_ff == 6'h3f) ? hold_ff : hold_ff + 6'h01;
      per_ff  <= (per_ff == 6'h3f) ? per_ff : per_ff + 6'h01;
      if (go) begin
        ack_ff  <= dt_in ? ~ack_ff : 1'b1;
        hold_ff <= 6'h01;
        if (!ack_ff) begin
          per_ff <= 6'h01;
        end
      end else if (!dt_in && ack_ff && hold_ff >= lim.asrt) begin
        ack_ff  <= 1'b0;
        hold_ff <= 6'h01;
      end
    end
  end

endmodule

// >>> design/bus_phase_timer.sv
// Device end: control phase timers, arbitration and paced data strobes
//
// Functional notes
// - Sample arbitration result after arbitration delay
// - Release bus on free, foreign select, reset
// - Bus-free release within limit from lines false
// - Slow free detection shortens the release window
// - Bus free needs settle time both false
// - Wait bus free delay before asserting busy
// - Busy and ID driven within bus set delay
// - Allow settle time after own control change
// - Initiator drops data when direction turns true
// - Disconnect holdoff before next arbitration
// - Signal readiness after power-on interval
// - Single-transition strobe period per rate class
// - Single-transition strobe high and low minimums
// - Double transition carries data both edges
// - Double-transition strobe period per rate class
// - Double-transition strobe high and low minimums
// - Class fastest-rate limits always apply
// - Hold driven reset at least reset hold
// - No busy answer after selection abort time
// - Deskew before trusting selection, not in transfers
`timescale 1ns/10ps
module bus_phase_timer
  import bus_timing_pkg::*;
#(
  parameter int DISC_CYC  = `DISC_CYC,
  parameter int ABORT_CYC = `ABORT_CYC,
  parameter int POWER_CYC = int'(`POWER_CYC)
)(
  input  wire logic             clock_in,        // System clock
  input  wire logic             reset_in,        // Async reset, high
  par_bus_if.dev_mp             bus,             // Bus side
  input  wire logic [2:0]       own_id_in,       // Own bus ID
  input  wire logic             role_tgt_in,     // High: target, low: initiator
  input  wire logic             arb_req_in,      // Request arbitration
  input  wire logic             sel_resp_in,     // Answer a selection
  input  wire logic             disc_in,         // Drop the connection
  input  wire logic             bus_rst_req_in,  // Drive a bus reset
  input  wire logic             dt_in,           // Double-transition mode
  input  wire logic [1:0]       rate_in,         // Rate class
  input  wire logic             xfer_valid_in,   // Word to send
  input  wire logic [`DAT_W-1:0] xfer_data_in,   // Word to send
  output logic                  xfer_ready_out,  // Word accepted when valid
  output logic                  bus_free_out,    // Bus free detected
  output logic                  selected_out,    // Selection seen
  output logic                  arb_won_out,     // Arbitration won pulse
  output logic                  arb_lost_out,    // Arbitration lost pulse
  output logic                  connected_out,   // Holding busy
  output logic                  power_ready_out  // Power-on interval over
);
  localparam logic [5:0]  SETTLE_C = 6'(`SETTLE_CYC);
  localparam logic [5:0]  DESKEW_C = 6'(`DESKEW_CYC);
  localparam logic [7:0]  FREE_C   = 8'(`FREE_CYC);
  localparam logic [7:0]  SET_C    = 8'(`SET_CYC - `SYNC_LAG);
  localparam logic [15:0] ARB_C    = 16'(`ARB_CYC);
  localparam logic [15:0] RST_C    = 16'(`RST_HOLD_CYC);
  localparam logic [15:0] DISC_C   = 16'(DISC_CYC);
  localparam logic [15:0] ABORT_C  = 16'(ABORT_CYC);
  localparam logic [30:0] POWER_C  = 31'(POWER_CYC);

  logic [`CTL_W+`DAT_W-1:0] sync1_ff;
  logic [`CTL_W+`DAT_W-1:0] sync2_ff;
  logic [`CTL_W-1:0]        prev_ff;
  logic [`CTL_W-1:0]        ctl_s;
  logic [`DAT_W-1:0]        dat_s;
  logic [`CTL_W-1:0]        drv;
  dev_state_e               state_ff;
  logic [15:0]              tmr_ff;
  logic [5:0]               free_cnt_ff;
  logic [7:0]               free_age_ff;
  logic [5:0]               settle_ff;
  logic [5:0]               desk_ff;
  logic [15:0]              abort_ff;
  logic [30:0]              pwr_ff;
  logic                     bsy_drv_ff;
  logic                     bsy_prev_ff;
  logic                     rst_drv_ff;
  logic                     req_ff;
  logic [5:0]               hold_ff;
  logic [5:0]               per_ff;
  logic [`DAT_W-1:0]        dat_oe_ff;
  logic [`DAT_W-1:0]        dat_out_ff;
  logic [`DAT_W-1:0]        id_oh;
  logic                     rst_rise;
  logic                     io_rise;
  logic                     free_rise;
  logic                     sel_cand;
  logic                     sel_ok;
  logic                     conn_ok;
  logic                     send;
  strobe_lim_s              lim;

  always_comb begin
    drv           = '0;
    drv[`CTL_BSY] = bsy_drv_ff;
    drv[`CTL_RST] = rst_drv_ff;
    drv[`CTL_REQ] = req_ff;
  end

  assign bus.dev_ctl_out = drv;
  assign bus.dev_ctl_oe  = drv;
  assign bus.dev_dat_out = dat_out_ff;
  assign bus.dev_dat_oe  = dat_oe_ff;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff  <= '0;
    end else begin
      sync1_ff <= {bus.dat, bus.ctl};
      sync2_ff <= sync1_ff;
      prev_ff  <= ctl_s;
    end
  end

  assign ctl_s     = sync2_ff[`CTL_W-1:0];
  assign dat_s     = sync2_ff[`CTL_W+`DAT_W-1:`CTL_W];
  assign rst_rise  = ctl_s[`CTL_RST] & ~prev_ff[`CTL_RST];
  assign io_rise   = ctl_s[`CTL_IO] & ~prev_ff[`CTL_IO];
  assign id_oh     = 8'h01 << own_id_in;
  assign free_rise = (free_cnt_ff == SETTLE_C - 6'h01) && !bus_free_out;

  // Free only after busy and select stay false a full settle time
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      free_cnt_ff  <= '0;
      bus_free_out <= 1'b0;
    end else if (ctl_s[`CTL_BSY] || ctl_s[`CTL_SEL]) begin
      free_cnt_ff  <= '0;
      bus_free_out <= 1'b0;
    end else if (free_cnt_ff != SETTLE_C) begin
      free_cnt_ff  <= free_cnt_ff + 6'h01;
      bus_free_out <= free_rise | bus_free_out;
    end
  end

  // Age since detection; a long idle bus counts as a fresh detection
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      free_age_ff <= '0;
    end else if (!bus_free_out || free_age_ff >= SET_C) begin
      free_age_ff <= '0;
    end else begin
      free_age_ff <= free_age_ff + 8'h01;
    end
  end

  // Own busy edge restarts the settle wait
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      bsy_prev_ff <= 1'b0;
      settle_ff   <= '0;
    end else begin
      bsy_prev_ff <= bsy_drv_ff;
      if (bsy_prev_ff != bsy_drv_ff) begin
        settle_ff <= '0;
      end else if (settle_ff != SETTLE_C) begin
        settle_ff <= settle_ff + 6'h01;
      end
    end
  end

  // Selection is trusted only after the deskew wait
  assign sel_cand = ctl_s[`CTL_SEL] & ~ctl_s[`CTL_BSY] & |(dat_s & id_oh);
  assign sel_ok   = selected_out && (abort_ff < ABORT_C);

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      desk_ff      <= '0;
      selected_out <= 1'b0;
      abort_ff     <= '0;
    end else begin
      abort_ff <= (abort_ff == 16'hffff) ? abort_ff : abort_ff + 16'h0001;
      if (!sel_cand) begin
        desk_ff      <= '0;
        selected_out <= 1'b0;
      end else if (desk_ff != DESKEW_C) begin
        desk_ff <= desk_ff + 6'h01;
      end else if (!selected_out) begin
        selected_out <= 1'b1;
        abort_ff     <= '0;
      end
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      state_ff     <= ST_IDLE;
      tmr_ff       <= '0;
      bsy_drv_ff   <= 1'b0;
      rst_drv_ff   <= 1'b0;
      arb_won_out  <= 1'b0;
      arb_lost_out <= 1'b0;
    end else begin
      arb_won_out  <= 1'b0;
      arb_lost_out <= 1'b0;
      tmr_ff       <= (tmr_ff == 16'hffff) ? tmr_ff : tmr_ff + 16'h0001;
      if (rst_rise && state_ff != ST_RST) begin
        state_ff   <= ST_IDLE;
        bsy_drv_ff <= 1'b0;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            if (bus_rst_req_in) begin
              state_ff   <= ST_RST;
              tmr_ff     <= '0;
              rst_drv_ff <= 1'b1;
            end else if (arb_req_in && bus_free_out && free_age_ff >= FREE_C) begin
              state_ff   <= ST_ARB;
              tmr_ff     <= '0;
              bsy_drv_ff <= 1'b1;
            end else if (sel_ok && sel_resp_in) begin
              state_ff   <= ST_CONN;
              bsy_drv_ff <= 1'b1;
            end
          end
          ST_ARB: begin
            if (ctl_s[`CTL_SEL]) begin
              state_ff     <= ST_IDLE;
              bsy_drv_ff   <= 1'b0;
              arb_lost_out <= 1'b1;
            end else if (tmr_ff >= ARB_C) begin
              if (~|(dat_s & ~(id_oh | (id_oh - 8'h01)))) begin
                state_ff    <= ST_CONN;
                arb_won_out <= 1'b1;
              end else begin
                state_ff     <= ST_IDLE;
                bsy_drv_ff   <= 1'b0;
                arb_lost_out <= 1'b1;
              end
            end
          end
          ST_CONN: begin
            if (disc_in) begin
              state_ff   <= role_tgt_in ? ST_HOLD : ST_IDLE;
              tmr_ff     <= '0;
              bsy_drv_ff <= 1'b0;
            end
          end
          ST_HOLD: begin
            if (tmr_ff >= DISC_C) begin
              state_ff <= ST_IDLE;
            end
          end
          ST_RST: begin
            if (tmr_ff >= RST_C) begin
              state_ff   <= ST_IDLE;
              rst_drv_ff <= 1'b0;
            end
          end
          default: begin
            state_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign conn_ok = (state_ff == ST_CONN) && role_tgt_in && (settle_ff == SETTLE_C);
  assign lim     = strobe_lim(dt_in, rate_in);
  assign send    = xfer_valid_in & xfer_ready_out;

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      connected_out <= 1'b0;
    end else begin
      connected_out <= bsy_drv_ff;
    end
  end

  // Ready lags the counters by one cycle; counters only grow between own strobe edges, so it stays safe
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      req_ff         <= 1'b0;
      hold_ff        <= 6'h3f;
      per_ff         <= 6'h3f;
      xfer_ready_out <= 1'b0;
    end else begin
      hold_ff <= (hold_ff == 6'h3f) ? hold_ff : hold_ff + 6'h01;
      per_ff  <= (per_ff == 6'h3f) ? per_ff : per_ff + 6'h01;
      xfer_ready_out <= conn_ok && !send && (hold_ff >= lim.asrt) &&
                        (dt_in ? (req_ff || per_ff >= lim.per) :
                         (!req_ff && per_ff >= lim.per));
      if (send) begin
        req_ff  <= dt_in ? ~req_ff : 1'b1;
        hold_ff <= 6'h01;
        if (!req_ff) begin
          per_ff <= 6'h01;
        end
      end else if (req_ff && hold_ff >= lim.asrt && (!dt_in || !conn_ok)) begin
        req_ff  <= 1'b0;
        hold_ff <= 6'h01;
      end
    end
  end

  // Any release trigger wins over a new drive of the data lines
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      dat_oe_ff  <= '0;
      dat_out_ff <= '0;
    end else if (rst_rise || (state_ff == ST_ARB && ctl_s[`CTL_SEL])) begin
      dat_oe_ff <= '0;
    end else if (free_rise) begin
      dat_oe_ff <= '0;
    end else if (!role_tgt_in && io_rise) begin
      dat_oe_ff <= '0;
    end else if (state_ff == ST_ARB) begin
      dat_oe_ff  <= id_oh;
      dat_out_ff <= id_oh;
    end else if (send) begin
      dat_oe_ff  <= '1;
      dat_out_ff <= xfer_data_in;
    end else if (state_ff != ST_CONN) begin
      dat_oe_ff <= '0;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      pwr_ff          <= '0;
      power_ready_out <= 1'b0;
    end else if (pwr_ff != POWER_C) begin
      pwr_ff <= pwr_ff + 31'h0000_0001;
    end else begin
      power_ready_out <= 1'b1;
    end
  end

endmodule

// >>> test/bus_timing_checker.sv
// Timing checker on the shared bus lines
`timescale 1ns/10ps
module bus_timing_checker
  import bus_timing_pkg::*;
#(
  parameter int DISC_CYC = 400 // Holdoff after a target drop
)(
  input wire logic               clock_in,    // System clock
  input wire logic               reset_in,    // Async reset, high
  input wire logic [`CTL_W-1:0]  dev_ctl_out, // Device line drive
  input wire logic [`CTL_W-1:0]  dev_ctl_oe,  // Device line enables
  input wire logic [`DAT_W-1:0]  dev_dat_out, // Device data drive
  input wire logic [`DAT_W-1:0]  dev_dat_oe,  // Device data enables
  input wire logic [`CTL_W-1:0]  ctl,         // Resolved lines
  input wire logic               dt_in,       // Double transition
  input wire logic [1:0]         rate_in      // Rate class
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  // Cycle counts of the fastest rate in each class at 8 ns
  localparam int PER [4] = '{25, 13, 7, 4};
  localparam int ASRT [8] = '{10, 4, 2, 1, 12, 6, 3, 2};
  logic [11:0] bsy_age_ff, idle_ff, gap_ff, rst_age_ff;
  wire         dbsy = dev_ctl_oe[`CTL_BSY] & dev_ctl_out[`CTL_BSY];
  wire         drst = dev_ctl_oe[`CTL_RST] & dev_ctl_out[`CTL_RST];
  wire [5:0]   lim_per = 6'(PER[rate_in]);
  wire [5:0]   lim_asrt = 6'(ASRT[{dt_in, rate_in}]);
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      bsy_age_ff <= 12'h000;
      idle_ff    <= 12'h000;
      gap_ff     <= 12'hfff;
      rst_age_ff <= 12'h000;
    end else begin
      bsy_age_ff <= dbsy ? bsy_age_ff + 12'(bsy_age_ff != 12'hfff) : 12'h000;
      idle_ff    <= (ctl[`CTL_BSY] | ctl[`CTL_SEL]) ? 12'h000 : idle_ff + 12'(idle_ff != 12'hfff);
      gap_ff     <= dbsy ? 12'h000 : gap_ff + 12'(gap_ff != 12'hfff);
      rst_age_ff <= drst ? rst_age_ff + 12'(rst_age_ff != 12'hfff) : 12'h000;
    end
  end
  sequence all_released;
    dev_ctl_oe == '0 && dev_dat_oe == '0;
  endsequence
  a_arb_wait: assert property (
    $fell(dbsy) && !ctl[`CTL_RST] && !ctl[`CTL_SEL] |-> bsy_age_ff >= 12'h012c)
    else $error("busy dropped before arbitration delay");
  a_free_wait: assert property ($rose(dbsy) |-> idle_ff >= 12'h0096)
    else $error("busy raised too soon after bus free");
  a_id_drive: assert property ($rose(dbsy) |=> $onehot(dev_dat_oe & dev_dat_out))
    else $error("own id not driven after busy");
  a_rst_release: assert property ($rose(ctl[`CTL_RST]) && !drst |-> ##[1:100] all_released)
    else $error("lines not released after bus reset");
  a_free_release: assert property (
    $fell(ctl[`CTL_BSY] | ctl[`CTL_SEL]) && !dbsy |-> ##[1:150] all_released)
    else $error("lines not released after bus free");
  a_data_release: assert property (
    $rose(ctl[`CTL_IO]) && !dev_ctl_oe[`CTL_IO] |-> ##[0:50] dev_dat_oe == '0)
    else $error("data not released after direction change");
  a_rst_hold: assert property ($fell(drst) |-> rst_age_ff >= 12'h0c35)
    else $error("bus reset held too short");
  a_disc_hold: assert property ($rose(dbsy) |-> gap_ff >= 12'(DISC_CYC))
    else $error("arbitration joined inside holdoff");
  for (genvar i = 0; i < 2; i++) begin : g_strobe
    logic [5:0] hi_ff, lo_ff, per_ff;
    logic       s_ff;
    wire        s = ctl[`CTL_REQ + i];
    always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
        {hi_ff, lo_ff, per_ff, s_ff} <= {6'h3f, 6'h3f, 6'h3f, 1'b0};
      end else begin
        s_ff   <= s;
        hi_ff  <= !s ? hi_ff : !s_ff ? 6'h01 : hi_ff + 6'(hi_ff != 6'h3f);
        lo_ff  <= s ? lo_ff : s_ff ? 6'h01 : lo_ff + 6'(lo_ff != 6'h3f);
        per_ff <= (s && !s_ff) ? 6'h01 : per_ff + 6'(per_ff != 6'h3f);
      end
    end
    a_strobe_space: assert property (
      s && !s_ff |-> per_ff >= lim_per && lo_ff >= lim_asrt)
      else $error("strobe period or low time short");
    a_strobe_high: assert property (!s && s_ff |-> hi_ff >= lim_asrt)
      else $error("strobe high time short");
  end
endmodule

// >>> test/parallel_bus_phase_timing_tb_top.sv
// Bench joining the device end and the far end on one bus
`timescale 1ns/10ps
module parallel_bus_phase_timing_tb_top;
  import bus_timing_pkg::*;
  logic       clock_in, reset_in, arb, sresp, disc, brst, tgt, dt, xv;
  logic       bsy, sel, rst, io, pdrv, rdy, free, seld, won, lost, conn, pwr, rxv;
  logic [1:0] rate;
  logic [7:0] xd, pdat, rxd;
  int         failures, checked, cyc, n;
  par_bus_if bus ();
  bus_phase_timer #(.DISC_CYC(400), .ABORT_CYC(40), .POWER_CYC(100)) bus_phase_timer_i (
    .clock_in(clock_in), .reset_in(reset_in), .bus(bus), .own_id_in(3'h7),
    .role_tgt_in(tgt), .arb_req_in(arb), .sel_resp_in(sresp), .disc_in(disc),
    .bus_rst_req_in(brst), .dt_in(dt), .rate_in(rate), .xfer_valid_in(xv),
    .xfer_data_in(xd), .xfer_ready_out(rdy), .bus_free_out(free), .selected_out(seld),
    .arb_won_out(won), .arb_lost_out(lost), .connected_out(conn), .power_ready_out(pwr));
  bus_peer_end bus_peer_end_i (.clock_in(clock_in), .reset_in(reset_in), .bus(bus),
    .bsy_in(bsy), .sel_in(sel), .rst_in(rst), .io_in(io), .dat_drive_in(pdrv),
    .dat_in(pdat), .dt_in(dt), .rate_in(rate), .rx_data_out(rxd), .rx_valid_out(rxv));
  bus_timing_checker #(.DISC_CYC(400)) bus_timing_checker_i (.clock_in(clock_in),
    .reset_in(reset_in), .dev_ctl_out(bus.dev_ctl_out), .dev_ctl_oe(bus.dev_ctl_oe),
    .dev_dat_out(bus.dev_dat_out), .dev_dat_oe(bus.dev_dat_oe), .ctl(bus.ctl),
    .dt_in(dt), .rate_in(rate));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  // Bounded poll at the falling edge, so one-cycle pulses are seen
  task automatic wait_for(ref logic s, input int lim, output int cnt);
    cnt = 0;
    while (s !== 1'b1 && cnt < lim) begin
      @(negedge clock_in);
      cnt++;
    end
    chk("wait_limit", 1, s);
  endtask
  task automatic send(input logic [7:0] w);
    wait_for(rdy, 200, n);
    xv = 1'b1;
    xd = w;
    @(negedge clock_in);
    xv = 1'b0;
    wait_for(rxv, 200, n);
    chk("rx_word", {8'h00, w}, {8'h00, rxd});
    // Ready lags the limits, so let the strobe counters pass every limit before a mode change
    repeat (30) @(negedge clock_in);
  endtask
  task automatic test_done();
    $display("Counts: %0d checked, %0d failures", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    {arb, sresp, disc, brst, dt, xv, bsy, sel, rst, io, pdrv} = '0;
    {tgt, rate, xd, pdat, reset_in} = {1'b1, 2'h0, 8'h00, 8'h00, 1'b1};
    repeat (6) @(negedge clock_in);
    reset_in = 1'b0;
    arb = 1'b1;
    wait_for(conn, 600, n);
    @(negedge clock_in);
    chk("own_id", 16'h0080, {8'h00, bus.dat});
    wait_for(won, 600, n);
    arb = 1'b0;
    chk("arb_delay", 1, n >= 298);
    chk("power_ready", 1, pwr);
    $display("arbitration test done");
    for (int m = 0; m < 16; m++) begin
      dt = m[3];
      rate = m[2:1];
      send(8'h3c + 8'(m));
    end
    $display("strobe test done");
    disc = 1'b1;
    @(negedge clock_in);
    {disc, arb} = 2'b01;
    repeat (5) @(negedge clock_in);
    chk("dropped", 0, conn);
    wait_for(conn, 1500, n);
    chk("holdoff", 1, n >= 390);
    wait_for(won, 600, n);
    arb = 1'b0;
    $display("holdoff test done");
    rst = 1'b1;
    repeat (100) @(negedge clock_in);
    chk("released", 0, {2'h0, bus.dev_ctl_oe, bus.dev_dat_oe});
    rst = 1'b0;
    repeat (10) @(negedge clock_in);
    brst = 1'b1;
    for (n = 0; bus.ctl[`CTL_RST] !== 1'b1 && n < 20; n++) @(negedge clock_in);
    brst = 1'b0;
    for (n = 0; bus.ctl[`CTL_RST] === 1'b1 && n < 5000; n++) @(negedge clock_in);
    chk("rst_hold", 1, n >= 3125);
    $display("reset test done");
    chk("bus_free", 1, free);
    {sel, pdrv, pdat} = {2'b11, 8'h80};
    wait_for(seld, 30, n);
    chk("deskew", 1, n >= 6);
    repeat (50) @(negedge clock_in);
    sresp = 1'b1;
    repeat (10) @(negedge clock_in);
    chk("abort", 0, conn);
    {sresp, sel, pdrv} = '0;
    $display("selection test done");
    {tgt, arb} = 2'b01;
    wait_for(conn, 900, n);
    sel = 1'b1;
    wait_for(lost, 20, n);
    {sel, arb} = 2'b00;
    repeat (450) @(negedge clock_in);
    chk("lost_release", 0, {2'h0, bus.dev_ctl_oe, bus.dev_dat_oe});
    arb = 1'b1;
    wait_for(won, 900, n);
    io = 1'b1;
    repeat (50) @(negedge clock_in);
    chk("data_release", 0, {8'h00, bus.dev_dat_oe});
    $display("initiator test done");
    test_done();
  end
endmodule
